// ===== common/l2im_pkg.sv
package l2im_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int REG_W = 16;
	localparam int ADDR_W = 12;
	localparam int GIO_PINS = 12;
	localparam int SER_SRCS = 14;
	localparam int EVT_W = 2;

	// ----------------------------------------
	// Register indices, byte address is 4x
	// ----------------------------------------
	localparam logic [31:0] GIO_MASK_IDX = 32'h0b00_0094;
	localparam logic [31:0] SER_MASK_IDX = 32'h0b00_0096;
	localparam logic [31:0] EVT_STAT_IDX = 32'h0b00_009c;
	localparam logic [31:0] EVT_MASK_IDX = 32'h0b00_009e;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GIO_CD_BIT = 13;
	localparam int GIO_PIN_LSB = 0;
	localparam int SER_TX_FIRST_BIT = 0;
	localparam int SER_TX_SECOND_BIT = 1;
	localparam int SER_RX_FIRST_BIT = 2;
	localparam int SER_RX_SECOND_BIT = 3;
	localparam int SER_RX_DONE_BIT = 4;
	localparam int SER_RX_LOST_BIT = 5;
	localparam int SER_CTS_BIT = 6;
	localparam int SER_DSR_BIT = 7;
	localparam int SER_DCD_BIT = 8;
	localparam int SER_FRAMING_BIT = 9;
	localparam int SER_BREAK_BIT = 10;
	localparam int SER_TX_IRQ_BIT = 11;
	localparam int SER_RX_IRQ_BIT = 12;
	localparam int SER_ERR_IRQ_BIT = 13;
	localparam int EVT_GIO_BIT = 0;
	localparam int EVT_SER_BIT = 1;

	// ----------------------------------------
	// Writable bits and reset values
	// ----------------------------------------
	localparam logic [REG_W-1:0] GIO_WR_MASK = 16'h2fff;
	localparam logic [REG_W-1:0] SER_WR_MASK = 16'h3fff;
	localparam logic [REG_W-1:0] EVT_WR_MASK = 16'h0003;
	localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	function automatic logic [ADDR_W-1:0] byteAddr(logic [31:0] idx);
		byteAddr = {idx[ADDR_W-3:0], 2'b00};
	endfunction
endpackage

// ===== common/l2im_gate_if.sv
`timescale 1ns/1ps
interface l2im_gate_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] pend;
	logic [WIDTH-1:0] mask;
	logic req;
	logic evt;
	modport ctl (output pend, output mask, input req, input evt);
	modport gate (input pend, input mask, output req, output evt);
endinterface

// ===== logic/l2im_gate.sv
`timescale 1ns/1ps
module l2im_gate
	import l2im_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	l2im_gate_if.gate gif
);
	logic req_r;

	// ----------------------------------------
	// Masked request to first level
	// ----------------------------------------
	// pending and enabled
	assign gif.req = |(gif.pend & gif.mask);
	assign gif.evt = gif.req & ~req_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_r <= 1'b0;
		end else begin
			req_r <= gif.req;
		end
	end
endmodule

// ===== logic/l2im_evt_stat.sv
`timescale 1ns/1ps
module l2im_evt_stat
	import l2im_pkg::*;
#(
	parameter int WIDTH = EVT_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] evt,
	input wire logic clrWr,
	input wire logic [WIDTH-1:0] clrData,
	input wire logic maskWr,
	input wire logic [WIDTH-1:0] maskData,
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] mask,
	output logic irq
);
	// ----------------------------------------
	// Sticky status, set wins over clear
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else if (clrWr) begin
			status <= (status & ~clrData) | evt;
		end else begin
			status <= status | evt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mask <= '0;
		end else if (maskWr) begin
			mask <= maskData;
		end
	end

	assign irq = |(status & mask);
endmodule

// ===== logic/l2im_top.sv
`timescale 1ns/1ps
module l2im_top
	import l2im_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [GIO_PINS-1:0] gpioPinIrq,
	input wire logic carrierDetectIrq,
	input wire logic [SER_SRCS-1:0] serialIrq,
	input wire logic [SER_SRCS-1:0] debugSerialIrq,
	output logic gioLevel1Req,
	output logic serLevel1Req,
	output logic irq
);
	logic [REG_W-1:0] gioMask_r;
	logic [REG_W-1:0] serMask_r;
	logic [EVT_W-1:0] evtStatus;
	logic [EVT_W-1:0] evtMask;
	logic access;
	logic wrAccess;
	logic hitGio;
	logic hitSer;
	logic hitStat;
	logic hitEvtMask;
	logic [31:0] prdata_nxt;

	l2im_gate_if #(.WIDTH(REG_W)) gioIf ();
	l2im_gate_if #(.WIDTH(REG_W)) serIf ();

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign access = psel & penable;
	assign wrAccess = access & pwrite;
	assign hitGio = (paddr == byteAddr(GIO_MASK_IDX));
	assign hitSer = (paddr == byteAddr(SER_MASK_IDX));
	assign hitStat = (paddr == byteAddr(EVT_STAT_IDX));
	assign hitEvtMask = (paddr == byteAddr(EVT_MASK_IDX));
	assign pready = 1'b1;
	assign pslverr = access & ~(hitGio | hitSer | hitStat | hitEvtMask);

	// ----------------------------------------
	// Mask registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gioMask_r <= MASK_RESET;
		end else if (wrAccess && hitGio) begin
			gioMask_r <= pwdata[REG_W-1:0] & GIO_WR_MASK;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serMask_r <= MASK_RESET;
		end else if (wrAccess && hitSer) begin
			serMask_r <= pwdata[REG_W-1:0] & SER_WR_MASK;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		prdata_nxt = RDATA_ZERO;
		if (hitGio) begin
			prdata_nxt[REG_W-1:0] = gioMask_r;
		end else if (hitSer) begin
			prdata_nxt[REG_W-1:0] = serMask_r;
		end else if (hitStat) begin
			prdata_nxt[EVT_W-1:0] = evtStatus;
		end else if (hitEvtMask) begin
			prdata_nxt[EVT_W-1:0] = evtMask;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata <= RDATA_ZERO;
		end else if (psel && !penable && !pwrite) begin
			prdata <= prdata_nxt;
		end
	end

	// ----------------------------------------
	// I/O group gating
	// ----------------------------------------
	always_comb begin
		gioIf.pend = '0;
		gioIf.pend[GIO_PIN_LSB +: GIO_PINS] = gpioPinIrq;
		gioIf.pend[GIO_CD_BIT] = carrierDetectIrq;
	end
	assign gioIf.mask = gioMask_r;

	l2im_gate #(.WIDTH(REG_W)) gioGate (
		.core_clk(core_clk),
		.rst(rst),
		.gif(gioIf.gate)
	);

	// ----------------------------------------
	// Serial group gating
	// ----------------------------------------
	always_comb begin
		serIf.pend = '0;
		serIf.pend[SER_SRCS-1:0] = serialIrq | debugSerialIrq;
	end
	assign serIf.mask = serMask_r;

	l2im_gate #(.WIDTH(REG_W)) serGate (
		.core_clk(core_clk),
		.rst(rst),
		.gif(serIf.gate)
	);

	assign gioLevel1Req = gioIf.req;
	assign serLevel1Req = serIf.req;

	// ----------------------------------------
	// Event status and interrupt
	// ----------------------------------------
	l2im_evt_stat #(.WIDTH(EVT_W)) evtStat (
		.core_clk(core_clk),
		.rst(rst),
		.evt({serIf.evt, gioIf.evt}),
		.clrWr(wrAccess && hitStat),
		.clrData(pwdata[EVT_W-1:0]),
		.maskWr(wrAccess && hitEvtMask),
		.maskData(pwdata[EVT_W-1:0]),
		.status(evtStatus),
		.mask(evtMask),
		.irq(irq)
	);
endmodule

// ===== tb/l2im_chk.sv
`timescale 1ns/1ps
module l2im_chk
	import l2im_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [GIO_PINS-1:0] gpioPinIrq,
	input wire logic carrierDetectIrq,
	input wire logic [SER_SRCS-1:0] serialIrq,
	input wire logic [SER_SRCS-1:0] debugSerialIrq,
	input wire logic gioLevel1Req,
	input wire logic serLevel1Req,
	input wire logic irq
);
	logic [15:0] gM_r;
	logic [15:0] sM_r;
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr inside {12'h250, 12'h258, 12'h270, 12'h278};
	// ----------------------------------------
	// Mask shadows
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gM_r <= 16'h0000;
			sM_r <= 16'h0000;
		end else if (acc && pwrite && paddr == 12'h250) begin
			gM_r <= pwdata[15:0] & GIO_WR_MASK;
		end else if (acc && pwrite && paddr == 12'h258) begin
			sM_r <= pwdata[15:0] & SER_WR_MASK;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	a_gio_gate: assert property (
		gioLevel1Req ==
		|({carrierDetectIrq, 1'b0, gpioPinIrq} & gM_r[13:0]))
		else $error("gio request wrong");
	a_ser_gate: assert property (
		serLevel1Req == |((serialIrq | debugSerialIrq) & sM_r[13:0]))
		else $error("serial request wrong");
	a_bad_addr_err: assert property (acc && !mapped |-> pslverr)
		else $error("no error on unmapped");
	a_good_addr_ok: assert property (acc && mapped |-> !pslverr)
		else $error("error on mapped");
	a_gio_rsvd_zero: assert property (
		s_rd(12'h250) |-> prdata[15:14] == 2'b00 && !prdata[12])
		else $error("gio reserved bits set");
	a_ser_rsvd_zero: assert property (
		s_rd(12'h258) |-> prdata[31:14] == 18'h0_0000)
		else $error("serial reserved bits set");
	a_gio_read_back: assert property (
		s_rd(12'h250) |-> prdata[15:0] == gM_r)
		else $error("gio readback wrong");
	a_ser_read_back: assert property (
		s_rd(12'h258) |-> prdata[15:0] == sM_r)
		else $error("serial readback wrong");
endmodule
bind l2im_top l2im_chk l2im_chk_inst (.*);

// ===== tb/l2im_src_model.sv
`timescale 1ns/1ps
module l2im_src_model
	import l2im_pkg::*;
(
	input wire logic [13:0] gioCmd,
	input wire logic [SER_SRCS-1:0] serCmd,
	input wire logic [SER_SRCS-1:0] dbgCmd,
	output logic [GIO_PINS-1:0] gpioPinIrq,
	output logic carrierDetectIrq,
	output logic [SER_SRCS-1:0] serialIrq,
	output logic [SER_SRCS-1:0] debugSerialIrq
);
	// Pending levels of the peripheral sources
	assign gpioPinIrq = gioCmd[11:0];
	assign carrierDetectIrq = gioCmd[13];
	assign serialIrq = serCmd;
	assign debugSerialIrq = dbgCmd;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
	import l2im_pkg::*;
;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] gioCmd, serCmd, dbgCmd, serialIrq, debugSerialIrq;
	logic [11:0] gpioPinIrq;
	logic carrierDetectIrq, gioLevel1Req, serLevel1Req, irq;
	int failCount, checksDone;
	l2im_top l2im_top_inst (.*);
	l2im_src_model l2im_src_model_inst (.*);
	initial begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic completeRun;
		if (failCount == 0 && checksDone > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0; penable <= 1'h0;
		if (n >= 20) begin
			failCount++;
			completeRun();
		end
		@(posedge core_clk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task automatic src(input logic [13:0] g, s, d);
		gioCmd <= g; serCmd <= s; dbgCmd <= d;
		@(posedge core_clk);
	endtask
	task automatic reqChk(input logic g, s);
		@(posedge core_clk);
		chk(32'(gioLevel1Req), 32'(g));
		chk(32'(serLevel1Req), 32'(s));
	endtask
	task automatic tReset;
		rdc(12'h250, 32'h0000_0000);
		rdc(12'h258, 32'h0000_0000);
		src(14'h3fff, 14'h3fff, 14'h3fff);
		reqChk(1'h0, 1'h0);
	endtask
	task automatic tGio;
		logic [13:0] b;
		for (int i = 0; i < 14; i++) begin
			if (i == 12) continue;
			b = 14'h0001 << i;
			src(b, 14'h0000, 14'h0000);
			bus(1'h1, 12'h250, {18'h0_0000, b});
			reqChk(1'h1, 1'h0);
			bus(1'h1, 12'h250, {18'h0_0000, 14'h2fff ^ b});
			reqChk(1'h0, 1'h0);
		end
		bus(1'h1, 12'h250, 32'h0000_2fff);
		rdc(12'h250, 32'h0000_2fff);
	endtask
	task automatic tSer;
		logic [13:0] b;
		for (int i = 0; i < 14; i++) begin
			b = 14'h0001 << i;
			src(14'h0000, b, 14'h0000);
			bus(1'h1, 12'h258, {18'h0_0000, b});
			reqChk(1'h0, 1'h1);
			src(14'h0000, 14'h0000, b);
			reqChk(1'h0, 1'h1);
			bus(1'h1, 12'h258, {18'h0_0000, 14'h3fff ^ b});
			reqChk(1'h0, 1'h0);
		end
		bus(1'h1, 12'h258, 32'h0000_3fff);
		rdc(12'h258, 32'h0000_3fff);
	endtask
	task automatic tBad;
		bus(1'h1, 12'h254, 32'hffff_ffff);
		chk(32'(err), 32'h0000_0001);
		rdc(12'h254, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
	endtask
	task automatic tIrq;
		src(14'h0000, 14'h0000, 14'h0000);
		bus(1'h1, 12'h270, 32'h0000_0003);
		rdc(12'h270, 32'h0000_0000);
		bus(1'h1, 12'h278, 32'h0000_0001);
		bus(1'h1, 12'h250, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		src(14'h0001, 14'h0000, 14'h0000);
		@(posedge core_clk);
		chk(32'(irq), 32'h0000_0001);
		rdc(12'h270, 32'h0000_0001);
		bus(1'h1, 12'h270, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		bus(1'h1, 12'h278, 32'h0000_0000);
		src(14'h0000, 14'h0000, 14'h0000);
		src(14'h0001, 14'h0000, 14'h0000);
		@(posedge core_clk);
		chk(32'(irq), 32'h0000_0000);
		rdc(12'h270, 32'h0000_0001);
		bus(1'h1, 12'h278, 32'h0000_0002);
		src(14'h0001, 14'h0001, 14'h0000);
		@(posedge core_clk);
		chk(32'(irq), 32'h0000_0001);
		rdc(12'h270, 32'h0000_0003);
	endtask
	task automatic tMidReset;
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		rdc(12'h250, 32'h0000_0000);
		rdc(12'h258, 32'h0000_0000);
		rdc(12'h270, 32'h0000_0000);
		rdc(12'h278, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		reqChk(1'h0, 1'h0);
	endtask
	initial begin
		rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
		paddr = 12'h000; pwdata = 32'h0000_0000;
		gioCmd = 14'h0000; serCmd = 14'h0000; dbgCmd = 14'h0000;
		failCount = 0;
		checksDone = 0;
		repeat (6) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		tReset();
		tGio();
		tSer();
		tBad();
		tIrq();
		tMidReset();
		completeRun();
	end
endmodule
